/* rtl/ssd_decoder.sv */
// Script I/O and read/write instruction decoder with Wishbone registers
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "ssd_regs.svh"
module ssd_decoder (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sel_phase_i,
  input  wire logic        sel_fail_i,
  output logic             scsi_atn_o,
  output logic             scsi_atn_oe_o,
  output logic             scsi_ack_o,
  output logic             scsi_ack_oe_o,
  output logic             illegal_o,
  output logic             alt_fetch_o,
  output logic      [31:0] alt_addr_o,
  output logic      [3:0]  dest_id_o
);

  ////////////////////////////////////////////////////////////////////////////
  // ALU
  function automatic logic [8:0] ssd_alu(input logic [2:0] op,
                                         input logic [7:0] src,
                                         input logic [7:0] opnd,
                                         input logic       cin);
    logic [8:0] r;
    r = 9'h000;
    unique case (ssd_pkg::ssd_alu_op_t'(op))
      ssd_pkg::SSD_ALU_LOAD: r = {cin, opnd};
      ssd_pkg::SSD_ALU_SHL:  r = {src[7], src[6:0], 1'b0};
      ssd_pkg::SSD_ALU_OR:   r = {cin, src | opnd};
      ssd_pkg::SSD_ALU_XOR:  r = {cin, src ^ opnd};
      ssd_pkg::SSD_ALU_AND:  r = {cin, src & opnd};
      ssd_pkg::SSD_ALU_SHR:  r = {src[0], 1'b0, src[7:1]};
      ssd_pkg::SSD_ALU_ADD:  r = {1'b0, src} + {1'b0, opnd};
      ssd_pkg::SSD_ALU_ADC:  r = {1'b0, src} + {1'b0, opnd} + {8'h00, cin};
    endcase
    return r;
  endfunction : ssd_alu

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  ssd_pkg::ssd_word_t ir0_q;
  ssd_pkg::ssd_word_t ir1_q;
  ssd_pkg::ssd_word_t dsp_q;
  ssd_pkg::ssd_word_t dest_q;
  ssd_pkg::ssd_byte_t sctl0_q;
  ssd_pkg::ssd_byte_t ocl_q;
  ssd_pkg::ssd_byte_t scsi_test_second_q;
  ssd_pkg::ssd_byte_t fbr_q;
  ssd_pkg::ssd_byte_t rfile_q [0:127];
  logic               carry_q;
  logic               go_q;
  logic               sel_atn_q;
  logic               io_pend_q;
  logic [2:0]         phase_s_q;
  logic [2:0]         fail_s_q;
  logic               phase_q;
  logic               fail_q;
  logic               fail_d;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fields
  logic       is_rw;
  logic [2:0] opc;
  logic [2:0] oper;
  logic [6:0] radr;
  logic [7:0] imm;
  logic [7:0] src;
  logic [7:0] opnd;
  logic [8:0] res;
  logic       is_set;
  logic       is_clr;
  logic       wr_en;
  logic       rd_en;
  logic       rf_hit;

  assign opc    = ir0_q[29:27];
  assign is_rw  = (opc > `SSD_OPC_CLEAR);
  assign oper   = ir0_q[26:24];
  assign radr   = ir0_q[22:16];
  assign imm    = ir0_q[15:8];
  assign is_set = go_q && !is_rw && (opc == `SSD_OPC_SET);
  assign is_clr = go_q && !is_rw && (opc == `SSD_OPC_CLEAR);
  // Move from first-byte takes it as source, others the addressed register
  assign src    = (opc == `SSD_OPC_FROMFBR) ? fbr_q : rfile_q[radr];
  assign opnd   = ir0_q[`SSD_IR_USEFBR] ? fbr_q : imm;
  assign res    = ssd_alu(oper, src, opnd, carry_q);
  assign wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rd_en  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign rf_hit = (wb_adr_i[11:9] == 3'h1) && (wb_adr_i[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_s_q <= 3'h0;
      fail_s_q  <= 3'h0;
      phase_q   <= 1'b0;
      fail_q    <= 1'b0;
    end else begin
      phase_s_q <= {phase_s_q[1:0], sel_phase_i};
      fail_s_q  <= {fail_s_q[1:0], sel_fail_i};
      if (phase_s_q[1] == phase_s_q[2]) begin
        phase_q <= phase_s_q[2];
      end
      if (fail_s_q[1] == fail_s_q[2]) begin
        fail_q <= fail_s_q[2];
      end
    end
  end

  assign fail_d = (fail_s_q[1] == fail_s_q[2]) && fail_s_q[2] && !fail_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, writes land at the edge where ack is sampled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `SSD_RST_WORD;
    end else if (rd_en) begin
      wb_dat_o <= `SSD_RST_WORD;
      if (rf_hit) begin
        wb_dat_o <= {24'h000000, rfile_q[wb_adr_i[8:2]]};
      end else begin
        unique case (wb_adr_i)
          `SSD_OFS_INSTR0: wb_dat_o <= ir0_q;
          `SSD_OFS_INSTR1: wb_dat_o <= ir1_q;
          `SSD_OFS_STATUS: wb_dat_o <= {28'h0000000, sel_atn_q, alt_fetch_o,
                                        carry_q, illegal_o};
          `SSD_OFS_SCTL0:  wb_dat_o <= {24'h000000, sctl0_q};
          `SSD_OFS_OCL:    wb_dat_o <= {24'h000000, ocl_q};
          `SSD_OFS_SCSI_TEST_SECOND: wb_dat_o <= {24'h000000, scsi_test_second_q};
          `SSD_OFS_FBR:    wb_dat_o <= {24'h000000, fbr_q};
          `SSD_OFS_DSP:    wb_dat_o <= dsp_q;
          `SSD_OFS_ALT:    wb_dat_o <= alt_addr_o;
          `SSD_OFS_DEST:   wb_dat_o <= dest_q;
          `SSD_OFS_DSTID:  wb_dat_o <= {28'h0000000, dest_id_o};
          default:         wb_dat_o <= `SSD_RST_WORD;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction words, pointer and start pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir0_q <= `SSD_RST_WORD;
      ir1_q <= `SSD_RST_WORD;
      dsp_q <= `SSD_RST_WORD;
      go_q  <= 1'b0;
    end else begin
      go_q <= wr_en && wb_sel_i[0] && (wb_adr_i == `SSD_OFS_CTRL)
              && wb_dat_i[`SSD_BIT_GO];
      if (wr_en && (wb_adr_i == `SSD_OFS_INSTR0) && (wb_sel_i == 4'hf)) begin
        ir0_q <= wb_dat_i;
      end
      if (wr_en && (wb_adr_i == `SSD_OFS_INSTR1) && (wb_sel_i == 4'hf)) begin
        ir1_q <= wb_dat_i;
      end
      if (wr_en && (wb_adr_i == `SSD_OFS_DSP) && (wb_sel_i == 4'hf)) begin
        dsp_q <= wb_dat_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read/write execution: chip registers and first-byte register
  always_ff @(posedge clk_i) begin
    if (go_q && is_rw && (opc != `SSD_OPC_TOFBR)) begin
      rfile_q[radr] <= res[7:0];
    end else if (wr_en && rf_hit && wb_sel_i[0]) begin
      rfile_q[wb_adr_i[8:2]] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fbr_q  <= `SSD_RST_BYTE;
      dest_q <= `SSD_RST_WORD;
    end else if (go_q && is_rw) begin
      dest_q <= ir1_q;
      if (opc == `SSD_OPC_TOFBR) begin
        fbr_q <= res[7:0];
      end
    end else if (wr_en && wb_sel_i[0] && (wb_adr_i == `SSD_OFS_FBR)) begin
      fbr_q <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carry flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_q <= 1'b0;
    end else if ((is_set || is_clr) && ir0_q[`SSD_IR_CARRY]) begin
      carry_q <= is_set;
    end else if (go_q && is_rw) begin
      carry_q <= res[8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Role, output latch and test registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sctl0_q  <= `SSD_RST_BYTE;
      ocl_q    <= `SSD_RST_BYTE;
      scsi_test_second_q <= `SSD_RST_BYTE;
    end else begin
      if ((is_set || is_clr) && ir0_q[`SSD_IR_TARGET]) begin
        sctl0_q[`SSD_BIT_TARGET] <= is_set;
      end else if (wr_en && wb_sel_i[0] && (wb_adr_i == `SSD_OFS_SCTL0)) begin
        sctl0_q <= wb_dat_i[7:0];
      end
      if (is_set || is_clr) begin
        if (ir0_q[`SSD_IR_ACK]) begin
          ocl_q[`SSD_BIT_OCL_ACK] <= is_set;
        end
        if (ir0_q[`SSD_IR_ATN]) begin
          ocl_q[`SSD_BIT_OCL_ATN] <= is_set;
        end
      end else if (wr_en && wb_sel_i[0] && (wb_adr_i == `SSD_OFS_OCL)) begin
        ocl_q <= wb_dat_i[7:0];
      end
      if (wr_en && wb_sel_i[0] && (wb_adr_i == `SSD_OFS_SCSI_TEST_SECOND)) begin
        scsi_test_second_q <= wb_dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I/O decode: illegal flag, destination ID, select with attention
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      illegal_o <= 1'b0;
    end else if (go_q && !is_rw && ir0_q[`SSD_IR_SELATN]
                 && (opc != `SSD_OPC_SELECT)) begin
      illegal_o <= 1'b1;
    end else if (wr_en && wb_sel_i[0] && (wb_adr_i == `SSD_OFS_STATUS)
                 && wb_dat_i[`SSD_BIT_ILLEGAL]) begin
      illegal_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dest_id_o <= 4'h0;
      sel_atn_q <= 1'b0;
      io_pend_q <= 1'b0;
    end else if (go_q && !is_rw) begin
      dest_id_o <= ir0_q[19:16];
      io_pend_q <= (opc == `SSD_OPC_SELECT) || (opc == `SSD_OPC_WRESEL);
      sel_atn_q <= (opc == `SSD_OPC_SELECT) && ir0_q[`SSD_IR_SELATN];
    end else if (fail_d || (!phase_s_q[2] && phase_q
                            && (phase_s_q[1] == phase_s_q[2]))) begin
      sel_atn_q <= 1'b0;
      io_pend_q <= io_pend_q && !fail_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alternate fetch address on failed selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_addr_o  <= `SSD_RST_WORD;
      alt_fetch_o <= 1'b0;
    end else begin
      alt_fetch_o <= fail_d && io_pend_q;
      if (fail_d && io_pend_q) begin
        if (ir0_q[`SSD_IR_REL]) begin
          alt_addr_o <= dsp_q + {{8{ir1_q[23]}}, ir1_q[23:0]};
        end else begin
          alt_addr_o <= ir1_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SCSI drive, only as initiator or in loopback
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scsi_atn_o    <= 1'b0;
      scsi_atn_oe_o <= 1'b0;
      scsi_ack_o    <= 1'b0;
      scsi_ack_oe_o <= 1'b0;
    end else begin
      scsi_atn_o    <= ocl_q[`SSD_BIT_OCL_ATN] || (sel_atn_q && phase_q);
      scsi_ack_o    <= ocl_q[`SSD_BIT_OCL_ACK];
      scsi_atn_oe_o <= (!sctl0_q[`SSD_BIT_TARGET] || scsi_test_second_q[`SSD_BIT_LOOPBK])
                       && (ocl_q[`SSD_BIT_OCL_ATN] || (sel_atn_q && phase_q));
      scsi_ack_oe_o <= (!sctl0_q[`SSD_BIT_TARGET] || scsi_test_second_q[`SSD_BIT_LOOPBK])
                       && ocl_q[`SSD_BIT_OCL_ACK];
    end
  end

endmodule : ssd_decoder

/* rtl/ssd_pkg.sv */
// Types for the script instruction decoder
package ssd_pkg;
  typedef logic [7:0]  ssd_byte_t;
  typedef logic [31:0] ssd_word_t;
  typedef enum logic [2:0] {
    SSD_ALU_LOAD, SSD_ALU_SHL, SSD_ALU_OR, SSD_ALU_XOR,
    SSD_ALU_AND, SSD_ALU_SHR, SSD_ALU_ADD, SSD_ALU_ADC
  } ssd_alu_op_t;
endpackage : ssd_pkg

/* rtl/ssd_regs.svh */
// Constants for the script I/O and read/write instruction decoder
// How it works
// - Select with bit 24 set asserts ATN during the following selection phase.
// - Bit 24 on any other I/O instruction flags an illegal instruction.
// - Destination SCSI ID comes from instruction bits 19 down to 16.
// - Bit 10 makes Set force carry to one, Clear force it zero.
// - Bit 9 with Set enters target role; with Clear returns to initiator.
// - Bit 6 is ACK, bit 3 is ATN in the output control latch.
// - ACK and ATN reach the bus only as initiator or in loopback.
// - Failed selection or reselection fetches from the second dword address.
// - Relative modes add signed 24-bit second dword to the script pointer.
// - Read/write combines a chip register with the first-byte register.
// - Bits 31-30 type, 29-27 opcode; 000 to 100 are I/O.
// - Operator bits 26-24 with opcode 111, 110 or 101 pick the operation.
// - Bit 23 uses the first-byte register instead of the immediate byte.
// - Bits 22-16 address the 8-bit internal register.
// - Bits 15-8 give the immediate byte second operand.
// - Read-modify-write writes the result back into the addressed register.
// - Operator 000 loads the operand into the opcode's destination.
// - Operator 001 shifts left; opcode 101 takes the first-byte register.
// - Read/write second dword is held as the destination address.
// - Operators 010, 011, 100 are OR, XOR and AND.
// - Operator 101 shifts right by one bit.
// - Operator 110 adds without carry, 111 adds with carry.
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH
`define SSD_OFS_INSTR0   12'h000
`define SSD_OFS_INSTR1   12'h004
`define SSD_OFS_CTRL     12'h008
`define SSD_OFS_STATUS   12'h00c
`define SSD_OFS_SCTL0    12'h010
`define SSD_OFS_OCL      12'h014
`define SSD_OFS_SCSI_TEST_SECOND   12'h018
`define SSD_OFS_FBR      12'h01c
`define SSD_OFS_DSP      12'h020
`define SSD_OFS_ALT      12'h024
`define SSD_OFS_DEST     12'h028
`define SSD_OFS_DSTID    12'h02c
`define SSD_OFS_RFILE    12'h200
`define SSD_BIT_GO       0
`define SSD_BIT_ILLEGAL  0
`define SSD_BIT_CARRY    1
`define SSD_BIT_ALTVAL   2
`define SSD_BIT_SELATN   3
`define SSD_BIT_TARGET   0
`define SSD_BIT_OCL_ACK  6
`define SSD_BIT_OCL_ATN  3
`define SSD_BIT_LOOPBK   4
`define SSD_IR_SELATN    24
`define SSD_IR_REL       26
`define SSD_IR_TBL       25
`define SSD_IR_USEFBR    23
`define SSD_IR_CARRY     10
`define SSD_IR_TARGET    9
`define SSD_IR_ACK       6
`define SSD_IR_ATN       3
`define SSD_TYPE_RW      2'h1
`define SSD_TYPE_IO      2'h1
`define SSD_OPC_SELECT   3'h0
`define SSD_OPC_WDISC    3'h1
`define SSD_OPC_WRESEL   3'h2
`define SSD_OPC_SET      3'h3
`define SSD_OPC_CLEAR    3'h4
`define SSD_OPC_FROMFBR  3'h5
`define SSD_OPC_TOFBR    3'h6
`define SSD_OPC_RMW      3'h7
`define SSD_RST_BYTE     8'h00
`define SSD_RST_WORD     32'h0000_0000
`endif

/* tb/ssd_decoder_asserts.sv */
// Concurrent checks on the decoder ports
`timescale 1ns/100ps
module ssd_decoder_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic        sel_fail_i,
  input wire logic        illegal_o,
  input wire logic        alt_fetch_o,
  input wire logic [31:0] alt_addr_o,
  input wire logic [3:0]  dest_id_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] wr_hist_q;
  ////////////////////////////////////////////////////////////////////////////
  // Recent register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) wr_hist_q <= 6'h00;
    else wr_hist_q <= {wr_hist_q[4:0], wb_ack_o & wb_we_i};
  end
  sequence s_req_start;
    !(wb_cyc_i && wb_stb_i) ##1 (wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_fail_seen;
    $past(sel_fail_i, 3) || $past(sel_fail_i, 4) || $past(sel_fail_i, 5);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_req_gets_ack: assert property (s_req_start |-> ##1 wb_ack_o)
    else $error("request not answered in time");
  a_alt_after_fail: assert property ($rose(alt_fetch_o) |-> s_fail_seen)
    else $error("alternate fetch without failed selection");
  a_alt_one_pulse: assert property (alt_fetch_o |=> !alt_fetch_o)
    else $error("alternate fetch longer than one cycle");
  a_alt_addr_cause: assert property ($changed(alt_addr_o) |-> alt_fetch_o)
    else $error("alternate address changed without fetch pulse");
  a_illegal_sticky: assert property (illegal_o && !(wb_cyc_i && wb_we_i) |=> illegal_o)
    else $error("illegal flag dropped without write");
  a_illegal_cause: assert property ($rose(illegal_o) |-> |wr_hist_q)
    else $error("illegal flag without instruction");
  a_dest_id_cause: assert property ($changed(dest_id_o) |-> |wr_hist_q)
    else $error("destination id changed without instruction");
endmodule : ssd_decoder_asserts
bind ssd_decoder ssd_decoder_asserts ssd_decoder_asserts_i (.*);

/* tb/ssd_decoder_tb.sv */
// Self-checking bench for the script instruction decoder
`timescale 1ns/100ps
`include "ssd_regs.svh"
module ssd_decoder_tb;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sel_phase_i;
  logic        sel_fail_i;
  logic        scsi_atn_o;
  logic        scsi_atn_oe_o;
  logic        scsi_ack_o;
  logic        scsi_ack_oe_o;
  logic        illegal_o;
  logic        alt_fetch_o;
  logic [31:0] alt_addr_o;
  logic [3:0]  dest_id_o;
  logic        atn_seen;
  logic        alt_seen;
  logic [31:0] alt_got;
  logic [31:0] rd;
  logic [8:0]  ex;
  int          bad_count;
  int          samples_checked;
  ssd_decoder ssd_decoder_i (.*);
  ssd_scsi_peer ssd_scsi_peer_i (
    .clk_i       (clk_i),
    .atn_i       (scsi_atn_o),
    .atn_oe_i    (scsi_atn_oe_o),
    .sel_phase_o (sel_phase_i),
    .sel_fail_o  (sel_fail_i),
    .atn_seen_o  (atn_seen)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (alt_fetch_o === 1'b1) begin
      alt_seen <= 1'b1;
      alt_got  <= alt_addr_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  task automatic wbc(input logic we, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 40);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      chk("ack", 1, 0);
      print_verdict();
    end
  endtask : wbc
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string n);
    wbc(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rchk
  task automatic exec(input logic [31:0] i0, input logic [31:0] i1);
    wbc(1'b1, `SSD_OFS_INSTR0, i0);
    wbc(1'b1, `SSD_OFS_INSTR1, i1);
    wbc(1'b1, `SSD_OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk_i);
  endtask : exec
  function automatic logic [31:0] io(input logic [2:0] o, input logic [26:0] lo);
    return {`SSD_TYPE_IO, o, lo};
  endfunction : io
  function automatic logic [31:0] rw(input logic [2:0] o, input logic [2:0] f, input logic u,
                                     input logic [6:0] r, input logic [7:0] m);
    return {`SSD_TYPE_RW, o, f, u, r, m, 8'ha5};
  endfunction : rw
  function automatic logic [8:0] alu(input logic [2:0] f, input logic [7:0] a,
                                     input logic [7:0] b, input logic c);
    case (f)
      3'h0: return {c, b};
      3'h1: return {a[7], a[6:0], 1'b0};
      3'h2: return {c, a | b};
      3'h3: return {c, a ^ b};
      3'h4: return {c, a & b};
      3'h5: return {a[0], 1'b0, a[7:1]};
      3'h6: return {1'b0, a} + {1'b0, b};
      default: return {1'b0, a} + {1'b0, b} + {8'h0, c};
    endcase
  endfunction : alu
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    alt_seen = 1'b0;
    alt_got = 32'h0;
    bad_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(`SSD_OFS_STATUS, 32'h0, "status");
    chk("illegal", 0, illegal_o);
    wbc(1'b1, 12'h100, 32'hffff_ffff);
    rchk(12'h100, 32'h0, "unmapped");
    $display("test reset finished");
    exec(io(`SSD_OPC_SET, 27'h7cf), 32'h0);
    rchk(`SSD_OFS_SCTL0, 32'h1, "target");
    rchk(`SSD_OFS_OCL, 32'h48, "latch");
    rchk(`SSD_OFS_STATUS, 32'h2, "carry");
    chk("ack_oe", 0, scsi_ack_oe_o);
    wbc(1'b1, `SSD_OFS_SCSI_TEST_SECOND, 32'h10);
    repeat (3) @(posedge clk_i);
    chk("ack_oe", 1, scsi_ack_oe_o);
    chk("atn", 1, scsi_atn_o);
    wbc(1'b1, `SSD_OFS_SCSI_TEST_SECOND, 32'h0);
    exec(io(`SSD_OPC_CLEAR, 27'h200), 32'h0);
    rchk(`SSD_OFS_SCTL0, 32'h0, "target");
    chk("atn_oe", 1, scsi_atn_oe_o);
    exec(io(`SSD_OPC_CLEAR, 27'h448), 32'h0);
    rchk(`SSD_OFS_OCL, 32'h0, "latch");
    rchk(`SSD_OFS_STATUS, 32'h0, "carry");
    chk("ack", 0, scsi_ack_o);
    exec(io(`SSD_OPC_SET, 27'h040), 32'h0);
    exec(io(`SSD_OPC_SET, 27'h008), 32'h0);
    chk("ack", 1, scsi_ack_o);
    exec(io(`SSD_OPC_CLEAR, 27'h040), 32'h0);
    chk("atn", 1, scsi_atn_o);
    chk("ack", 0, scsi_ack_o);
    exec(io(`SSD_OPC_CLEAR, 27'h008), 32'h0);
    chk("atn", 0, scsi_atn_o);
    $display("test set_clear finished");
    exec(io(`SSD_OPC_SET, 27'h100_0000), 32'h0);
    chk("illegal", 1, illegal_o);
    wbc(1'b1, `SSD_OFS_STATUS, 32'h1);
    rchk(`SSD_OFS_STATUS, 32'h0, "status");
    exec(io(`SSD_OPC_SELECT, 27'h10a_0000), 32'h1000);
    chk("dest_id", 4'ha, dest_id_o);
    chk("illegal", 0, illegal_o);
    alt_seen <= 1'b0;
    ssd_scsi_peer_i.run_select(1'b1);
    chk("atn_seen", 1, atn_seen);
    chk("alt_seen", 1, alt_seen);
    chk("alt_addr", 32'h1000, alt_got);
    wbc(1'b1, `SSD_OFS_DSP, 32'h8000);
    exec(io(`SSD_OPC_SELECT, 27'h40b_0000), 32'h00ff_fff0);
    rchk(`SSD_OFS_DSTID, 32'hb, "dest_id");
    alt_seen <= 1'b0;
    ssd_scsi_peer_i.run_select(1'b1);
    chk("atn_seen", 0, atn_seen);
    chk("alt_seen", 1, alt_seen);
    chk("alt_addr", 32'h7ff0, alt_got);
    $display("test select finished");
    for (int f = 0; f < 8; f++) begin
      wbc(1'b1, `SSD_OFS_RFILE + 12'h014, 32'h96);
      exec(io(`SSD_OPC_SET, 27'h400), 32'h0);
      exec(rw(`SSD_OPC_RMW, f[2:0], 1'b0, 7'd5, 8'h3c), 32'h0);
      ex = alu(f[2:0], 8'h96, 8'h3c, 1'b1);
      rchk(`SSD_OFS_RFILE + 12'h014, {24'h0, ex[7:0]}, "rmw");
      wbc(1'b0, `SSD_OFS_STATUS, 32'h0);
      chk("carry", {31'h0, ex[8]}, {31'h0, rd[1]});
    end
    wbc(1'b1, `SSD_OFS_RFILE + 12'h1fc, 32'h21);
    exec(rw(`SSD_OPC_TOFBR, 3'h3, 1'b0, 7'h7f, 8'h0f), 32'h1234_0010);
    rchk(`SSD_OFS_FBR, 32'h2e, "to_fbr");
    rchk(`SSD_OFS_RFILE + 12'h1fc, 32'h21, "kept");
    rchk(`SSD_OFS_DEST, 32'h1234_0010, "dest");
    exec(rw(`SSD_OPC_FROMFBR, 3'h1, 1'b0, 7'h02, 8'h00), 32'h0);
    rchk(`SSD_OFS_RFILE + 12'h008, 32'h5c, "from_fbr");
    exec(rw(`SSD_OPC_RMW, 3'h6, 1'b1, 7'h7f, 8'h99), 32'h0);
    rchk(`SSD_OFS_RFILE + 12'h1fc, 32'h4f, "fbr_opnd");
    wbc(1'b1, `SSD_OFS_RFILE + 12'h00c, 32'h50);
    wbc(1'b1, `SSD_OFS_FBR, 32'h20);
    exec(rw(`SSD_OPC_FROMFBR, 3'h3, 1'b0, 7'h04, 8'hff), 32'h0);
    exec(rw(`SSD_OPC_TOFBR, 3'h6, 1'b0, 7'h04, 8'h01), 32'h0);
    exec(rw(`SSD_OPC_RMW, 3'h6, 1'b1, 7'h03, 8'h00), 32'h0);
    rchk(`SSD_OFS_FBR, 32'he0, "negated");
    rchk(`SSD_OFS_RFILE + 12'h00c, 32'h30, "difference");
    $display("test read_write finished");
    print_verdict();
  end
endmodule : ssd_decoder_tb

/* tb/ssd_scsi_peer.sv */
// Far-side SCSI device model for selection phases
`timescale 1ns/100ps
module ssd_scsi_peer (
  input  wire logic clk_i,
  input  wire logic atn_i,
  input  wire logic atn_oe_i,
  output logic      sel_phase_o,
  output logic      sel_fail_o,
  output logic      atn_seen_o
);
  initial begin
    sel_phase_o = 1'b0;
    sel_fail_o  = 1'b0;
    atn_seen_o  = 1'b0;
  end
  // Selection phase, optionally ending in failure
  task automatic run_select(input logic fail);
    @(posedge clk_i);
    atn_seen_o  <= 1'b0;
    sel_phase_o <= 1'b1;
    repeat (10) begin
      @(posedge clk_i);
      if (atn_i && atn_oe_i) atn_seen_o <= 1'b1;
    end
    sel_fail_o <= fail;
    repeat (8) @(posedge clk_i);
    sel_fail_o  <= 1'b0;
    sel_phase_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : run_select
endmodule : ssd_scsi_peer
